/* design/lcd_decoder.v */
// command/address decoder for a multiplexed ddr command bus
`timescale 1ns/1ps
`include "lcd_consts.vh"
// Functional notes
// RQ1: the controller issues only specified commands and timing, else re-initialises the device.
// RQ2: the command is chosen from chip select, ca0..ca3 and clock enable at the rising edge.
// RQ3: chip select and clock enable are sampled on rising edges only; the code leaves a power state on clock enable high in any mclk cycle.
// RQ4: ca bits are captured on both edges and paired rising then falling into one command.
// RQ5: bank commands take their bank from the three-bit bank field.
// RQ6: a read or write with auto precharge high precharges its bank after the access.
// RQ7: column bit zero is always zero.
// RQ8: precharge with the all-banks flag high hits every bank and ignores the bank field.
// RQ9: per-bank refresh is only sent to eight-bank devices.
// RQ10: a rise of clock enable leaves self refresh and deep power down regardless of decode.
// RQ11: the controller drives every don't-care ca position to a valid level.
// RQ12: with chip select low and clock enable high the rising opcode selects the command.
// RQ13: clock enable falling enters self refresh, deep power down or power down; rising exits.
// RQ14: mode, row and column fields are gathered from the rising and falling halves.
module lcd_decoder (
   input  wire        mclk_i,
   input  wire        nrst_i,
   input  wire        ck_rise_i,
   input  wire        ck_fall_i,
   input  wire        cs_n_i,
   input  wire        cke_i,
   input  wire [9:0]  ca_i,
   output reg         mode_register_write_o,
   output reg         mode_register_read_o,
   output reg         refresh_bank_o,
   output reg         refresh_all_o,
   output reg         activate_o,
   output reg         write_o,
   output reg         read_o,
   output reg         precharge_o,
   output reg         burst_terminate_o,
   output reg         nop_o,
   output reg         auto_precharge_flag_o,
   output reg         all_banks_flag_o,
   output reg  [2:0]  bank_select_o,
   output reg  [7:0]  bank_mask_o,
   output reg  [14:0] row_o,
   output reg  [11:0] col_o,
   output reg  [7:0]  mode_reg_addr_o,
   output reg  [7:0]  mode_reg_operand_o,
   output reg         self_refresh_o,
   output reg         deep_power_down_o,
   output reg         power_down_o,
   output reg         power_exit_o
);
   // one-hot decode states
   localparam ST_IDLE = 2'b01;
   localparam ST_HALF = 2'b10;

   wire        rise_s;
   wire        fall_s;
   wire        cs_n_s;
   wire        cke_s;
   wire [9:0]  ca_s;
   reg  [1:0]  st_r;
   reg  [1:0]  st_nxt;
   reg         cke_prev_r;
   reg  [9:0]  car_r;
   reg  [3:0]  cmd_r;
   reg  [1:0]  pstate_r;
   reg  [1:0]  pstate_nxt;

   // one-hot bank decode used for precharge and auto precharge
   function [7:0] bank_onehot;
      input [2:0] b;
      begin
         bank_onehot = 8'h01 << b;
      end
   endfunction

   // all pin inputs pass two flip-flops
   lcd_sync #(.W(14), .RST(1'b0)) u_sync (
      .mclk_i (mclk_i),
      .nrst_i (nrst_i),
      .d_i    ({ck_rise_i, ck_fall_i, cs_n_i, cke_i, ca_i}),
      .q_o    ({rise_s, fall_s, cs_n_s, cke_s, ca_s})
   );

   // command pairing state
   always @* begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (rise_s && !cs_n_s && cke_s && cke_prev_r)
               st_nxt = ST_HALF;
         end
         ST_HALF: begin
            if (fall_s)
               st_nxt = ST_IDLE; // RQ4
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   // power state from clock enable transitions
   always @* begin
      pstate_nxt = pstate_r;
      if (rise_s && cke_prev_r && !cke_s) begin
         if (cs_n_s)
            pstate_nxt = `LCD_PS_PDN; // RQ13
         else if (ca_s[2:0] == `LCD_PD_SELF_REFRESH)
            pstate_nxt = `LCD_PS_SELF_REFRESH; // RQ13
         else if (ca_s[2:0] == `LCD_PD_DPD)
            pstate_nxt = `LCD_PS_DPD; // RQ13
      end else if (cke_s && !cke_prev_r) begin
         pstate_nxt = `LCD_PS_ACTIVE; // RQ10
      end
   end

   // state registers and rising-edge capture
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r       <= ST_IDLE;
         cke_prev_r <= 1'b0;
         car_r      <= 10'h000;
         cmd_r      <= 4'h0;
         pstate_r   <= `LCD_PS_ACTIVE;
      end else begin
         st_r     <= st_nxt;
         pstate_r <= pstate_nxt;
         if (rise_s)
            cke_prev_r <= cke_s; // RQ3
         if (rise_s && st_r == ST_IDLE) begin
            car_r <= ca_s;
            cmd_r <= ca_s[3:0]; // RQ2
         end
      end
   end

   // output pulses and fields
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mode_register_write_o <= 1'b0;
         mode_register_read_o  <= 1'b0;
         refresh_bank_o        <= 1'b0;
         refresh_all_o         <= 1'b0;
         activate_o            <= 1'b0;
         write_o               <= 1'b0;
         read_o                <= 1'b0;
         precharge_o           <= 1'b0;
         burst_terminate_o     <= 1'b0;
         nop_o                 <= 1'b0;
         auto_precharge_flag_o <= 1'b0;
         all_banks_flag_o      <= 1'b0;
         bank_select_o         <= 3'h0;
         bank_mask_o           <= 8'h00;
         row_o                 <= 15'h0000;
         col_o                 <= 12'h000;
         mode_reg_addr_o       <= 8'h00;
         mode_reg_operand_o    <= 8'h00;
         self_refresh_o        <= 1'b0;
         deep_power_down_o     <= 1'b0;
         power_down_o          <= 1'b0;
         power_exit_o          <= 1'b0;
      end else begin
         mode_register_write_o <= 1'b0;
         mode_register_read_o  <= 1'b0;
         refresh_bank_o        <= 1'b0;
         refresh_all_o         <= 1'b0;
         activate_o            <= 1'b0;
         write_o               <= 1'b0;
         read_o                <= 1'b0;
         precharge_o           <= 1'b0;
         burst_terminate_o     <= 1'b0;
         nop_o                 <= 1'b0;
         power_exit_o          <= (pstate_r != `LCD_PS_ACTIVE) &&
                                  (pstate_nxt == `LCD_PS_ACTIVE); // RQ10
         self_refresh_o        <= (pstate_nxt == `LCD_PS_SELF_REFRESH);
         deep_power_down_o     <= (pstate_nxt == `LCD_PS_DPD);
         power_down_o          <= (pstate_nxt == `LCD_PS_PDN);
         // deselect with clock enable steady high is a nop
         if (rise_s && cs_n_s && cke_s && cke_prev_r)
            nop_o <= 1'b1;
         if (st_r == ST_HALF && fall_s) begin
            if (cmd_r == `LCD_OP_MRW) begin // RQ12
               mode_register_write_o <= 1'b1;
               mode_reg_addr_o       <= {ca_s[1:0], car_r[9:4]}; // RQ14
               mode_reg_operand_o    <= ca_s[9:2]; // RQ14
            end else if (cmd_r == `LCD_OP_MRR) begin // RQ12
               mode_register_read_o <= 1'b1;
               mode_reg_addr_o      <= {ca_s[1:0], car_r[9:4]}; // RQ14
            end else if (cmd_r == `LCD_OP_REFPB) begin
               refresh_bank_o <= 1'b1; // RQ12
            end else if (cmd_r == `LCD_OP_REFAB) begin
               refresh_all_o <= 1'b1; // RQ12
            end else if (cmd_r[1:0] == `LCD_OP_ACT2) begin // activate 01xx
               activate_o    <= 1'b1;
               bank_select_o <= car_r[9:7]; // RQ5
               row_o         <= {ca_s[9:8], car_r[6:2], ca_s[7:0]}; // RQ14
            end else if (cmd_r[1:0] == `LCD_OP_RW2) begin // write 100x / read 101x
               write_o               <= ~cmd_r[2];
               read_o                <= cmd_r[2];
               bank_select_o         <= car_r[9:7]; // RQ5
               col_o                 <= {ca_s[9:1], car_r[6:5], 1'b0}; // RQ7
               auto_precharge_flag_o <= ca_s[0];
               bank_mask_o           <= ca_s[0] ? bank_onehot(car_r[9:7]) : 8'h00; // RQ6
            end else if (cmd_r == `LCD_OP_PRE) begin // precharge 1101
               precharge_o      <= 1'b1;
               all_banks_flag_o <= car_r[4];
               bank_select_o    <= car_r[9:7]; // RQ5
               bank_mask_o      <= car_r[4] ? 8'hFF : bank_onehot(car_r[9:7]); // RQ8
            end else if (cmd_r == `LCD_OP_BST) begin
               burst_terminate_o <= 1'b1; // RQ12
            end else begin
               nop_o <= 1'b1; // RQ12
            end
         end
      end
   end
endmodule // lcd_decoder

/* inc/lcd_consts.vh */
// constants for the command/address decoder
`ifndef LCD_CONSTS_VH
`define LCD_CONSTS_VH
`define LCD_CA_W        10
`define LCD_ROW_W       15
`define LCD_COL_W       12
`define LCD_BANK_W      3
`define LCD_MRA_W       8
`define LCD_OP_W        8
// rising-edge opcodes on ca[3:0] (bit0 = ca0)
`define LCD_OP_MRW      4'h0
`define LCD_OP_MRR      4'h8
`define LCD_OP_REFPB    4'h4
`define LCD_OP_REFAB    4'hC
`define LCD_OP_PRE      4'hB
`define LCD_OP_BST      4'h3
// low two opcode bits of activate (01xx) and of read/write (10xx)
`define LCD_OP_ACT2     2'h2
`define LCD_OP_RW2      2'h1
// ca[2:0] patterns with clock enable falling and chip select low
`define LCD_PD_SELF_REFRESH     3'h4
`define LCD_PD_DPD      3'h3
// power state codes
`define LCD_PS_ACTIVE   2'h0
`define LCD_PS_PDN      2'h1
`define LCD_PS_SELF_REFRESH     2'h2
`define LCD_PS_DPD      2'h3
`endif

/* design/lcd_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lcd_sync #(
   parameter W   = 1,
   parameter RST = 1'b0
) (
   input  wire         mclk_i,
   input  wire         nrst_i,
   input  wire [W-1:0] d_i,
   output reg  [W-1:0] q_o
);
   reg [W-1:0] meta_r;
   // first stage feeds only the second
   always @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_r <= {W{RST}};
         q_o    <= {W{RST}};
      end else begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule // lcd_sync

/* testbench/lcd_ctrl_model.sv */
// controller model driving the command/address pins
`timescale 1ns/1ps
module lcd_ctrl_model (
   input  wire        clk_i,
   output logic       rise_o, fall_o, cs_n_o, cke_o,
   output logic [9:0] ca_o
);
   // idle: deselected, clock enable high
   initial {rise_o, fall_o, cs_n_o, cke_o, ca_o} = {4'h3, 10'h000};
   // one edge half, then a gap where the bus shows no stale value
   task automatic half(input logic r, input logic [9:0] v, input logic c, k);
      @(negedge clk_i);
      {rise_o, fall_o, ca_o, cs_n_o, cke_o} = {r, !r, v, c, k};
      @(negedge clk_i);
      {rise_o, fall_o, ca_o} = {2'h0, ~v};
   endtask
   // rising half then falling half; chip select flipped on the fall
   task automatic send(input logic [9:0] r, f, input logic c, k);
      half(1'b1, r, c, k);
      half(1'b0, f, !c, k);
   endtask
   // asynchronous wake
   task automatic wake;
      @(negedge clk_i);
      cke_o = 1'b1;
   endtask
endmodule // lcd_ctrl_model

/* testbench/lcd_decoder_asserts.sv */
// assertion checker for the decoder ports
`timescale 1ns/1ps
module lcd_decoder_chk (
   input wire        mclk_i, nrst_i, ck_rise_i, ck_fall_i, cs_n_i, cke_i,
   input wire        mode_register_write_o, mode_register_read_o, refresh_bank_o,
   input wire        refresh_all_o, activate_o, write_o, read_o, precharge_o,
   input wire        burst_terminate_o, nop_o, power_exit_o, auto_precharge_flag_o,
   input wire        all_banks_flag_o, self_refresh_o, deep_power_down_o, power_down_o,
   input wire [2:0]  bank_select_o,
   input wire [7:0]  bank_mask_o,
   input wire [11:0] col_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   // command pulses, power state, one-bank mask
   wire [9:0] cmds = {mode_register_write_o, mode_register_read_o, refresh_bank_o,
      refresh_all_o, activate_o, write_o, read_o, precharge_o, burst_terminate_o, nop_o};
   wire       pwr  = self_refresh_o | deep_power_down_o | power_down_o;
   wire [7:0] one  = 8'h01 << bank_select_o;
   property p_col0; col_o[0] == 1'b0; endproperty
   a_col0: assert property (p_col0) else $error("col0");
   property p_one; $onehot0(cmds); endproperty
   a_one: assert property (p_one) else $error("two cmds");
   // paired commands follow a fall marker, a deselect nop follows a rise marker
   property p_lat; |cmds |-> $past(ck_fall_i, 3) || (nop_o && $past(ck_rise_i, 3));
   endproperty
   a_lat: assert property (p_lat) else $error("latency");
   property p_cs; ck_rise_i && cs_n_i |-> ##5 !(|cmds); endproperty
   a_cs: assert property (p_cs) else $error("deselected");
   property p_ab; precharge_o && all_banks_flag_o |-> bank_mask_o == 8'hFF; endproperty
   a_ab: assert property (p_ab) else $error("all banks");
   property p_bank; precharge_o && !all_banks_flag_o |-> bank_mask_o == one; endproperty
   a_bank: assert property (p_bank) else $error("bank");
   property p_ap; read_o || write_o |-> bank_mask_o == (auto_precharge_flag_o ? one : 8'h00);
   endproperty
   a_ap: assert property (p_ap) else $error("autopre");
   property p_exit; pwr && cke_i |-> ##[1:4] power_exit_o; endproperty
   a_exit: assert property (p_exit) else $error("exit");
   property p_pwr; $onehot0({self_refresh_o, deep_power_down_o, power_down_o}); endproperty
   a_pwr: assert property (p_pwr) else $error("pwr");
   cover property (precharge_o && all_banks_flag_o);
   cover property (mode_register_write_o);
   cover property (power_exit_o);
endmodule // lcd_decoder_chk
bind lcd_decoder lcd_decoder_chk u_chk (.*);

/* testbench/lpddr2_command_decoder_bench.sv */
// self-checking bench for the decoder
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module lpddr2_command_decoder_bench;
   logic mclk_i = 1'b0, nrst_i = 1'b0;
   wire ck_rise_i, ck_fall_i, cs_n_i, cke_i;
   wire [9:0] ca_i;
   logic mode_register_write_o, mode_register_read_o, refresh_bank_o, refresh_all_o;
   logic activate_o, write_o, read_o, precharge_o, burst_terminate_o, nop_o, power_exit_o;
   logic auto_precharge_flag_o, all_banks_flag_o, self_refresh_o, deep_power_down_o;
   logic power_down_o;
   logic [2:0] bank_select_o;
   logic [7:0] bank_mask_o, mode_reg_addr_o, mode_reg_operand_o;
   logic [14:0] row_o;
   logic [11:0] col_o;
   logic [42:0] q[$], ex;
   logic [31:0] v;
   int fails = 0, num_checks = 0, seed = 90963, i;
   logic [3:0] cd[10] = '{4'h0, 4'h8, 4'h4, 4'hC, 4'h2, 4'h1, 4'h5, 4'hB, 4'h3, 4'h7};
   logic [3:0] fx[10] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'h3, 4'h7, 4'h7, 4'hF, 4'hF, 4'h7};
   wire [10:0] pv = {mode_register_write_o, mode_register_read_o, refresh_bank_o, refresh_all_o,
      activate_o, write_o, read_o, precharge_o, burst_terminate_o, nop_o, power_exit_o};
   always #20 mclk_i = ~mclk_i;
   lcd_ctrl_model u_mc (.clk_i(mclk_i), .rise_o(ck_rise_i), .fall_o(ck_fall_i),
      .cs_n_o(cs_n_i), .cke_o(cke_i), .ca_o(ca_i));
   lcd_decoder DUT (.*);
   // observed pulse plus the fields of its kind
   function automatic logic [42:0] obs();
      logic [31:0] f;
      f = 32'h0;
      if (pv[10]) f = {mode_reg_addr_o, mode_reg_operand_o};
      if (pv[9]) f = mode_reg_addr_o;
      if (pv[6]) f = {bank_select_o, row_o};
      if (pv[5] | pv[4]) f = {auto_precharge_flag_o, bank_select_o, col_o, bank_mask_o};
      if (pv[3]) f = {all_banks_flag_o, bank_mask_o, all_banks_flag_o ? 3'h0 : bank_select_o};
      return {pv, f};
   endfunction
   // send command kind k with random don't-care bits, note the result
   task automatic cmd(input int k);
      logic [9:0] r, f;
      logic [31:0] e;
      logic [7:0] m;
      v = $random(seed);
      r = v[9:0];
      f = v[19:10];
      r[3:0] = (r[3:0] & ~fx[k]) | cd[k];
      m = 8'h01 << r[9:7];
      case (k)
         0: e = {f[1:0], r[9:4], f[9:2]};
         1: e = {f[1:0], r[9:4]};
         4: e = {r[9:7], f[9:8], r[6:2], f[7:0]};
         5, 6: e = {f[0], r[9:7], f[9:1], r[6:5], 1'b0, f[0] ? m : 8'h00};
         7: e = {r[4], r[4] ? 8'hFF : m, r[4] ? 3'h0 : r[9:7]};
         default: e = 32'h0;
      endcase
      q.push_back({11'h400 >> k, e});
      u_mc.send(r, f, 1'b0, 1'b1);
   endtask
   task automatic drain;
      for (int n = 0; n < 20 && q.size() > 0; n++) @(negedge mclk_i);
      `CHK(q.size(), 0)
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // compare each pulse against the oldest note
   always @(negedge mclk_i) if (nrst_i && |pv) begin
      ex = q.size() ? q.pop_front() : 43'h0;
      `CHK(obs(), ex)
   end
   // watchdog
   initial begin
      repeat (3000) @(posedge mclk_i);
      fails++;
      stop_test;
   end
   // main sequence: every kind, random mix, then power states
   initial begin
      repeat (8) @(posedge mclk_i);
      @(negedge mclk_i) nrst_i = 1'b1;
      // first deselect only primes the clock-enable history, the second is a nop
      v = $random(seed);
      u_mc.send(v[9:0], v[19:10], 1'b1, 1'b1);
      q.push_back({11'h002, 32'h0});
      u_mc.send(v[19:10], v[9:0], 1'b1, 1'b1);
      for (i = 0; i < 70; i++) cmd(i < 10 ? i : int'($unsigned($random(seed)) % 10));
      drain;
      $display("test commands done");
      for (i = 0; i < 3; i++) begin
         u_mc.send(i == 2 ? 10'h000 : 10'h004 - i[9:0], 10'h000, i == 2, 1'b0);
         repeat (3) @(negedge mclk_i);
         `CHK({self_refresh_o, deep_power_down_o, power_down_o}, 3'h4 >> i)
         q.push_back({11'h001, 32'h0});
         u_mc.wake;
         repeat (6) @(negedge mclk_i);
         `CHK({self_refresh_o, deep_power_down_o, power_down_o}, 3'h0)
         v = $random(seed);
         u_mc.send(v[9:0], v[19:10], 1'b1, 1'b1);
      end
      drain;
      $display("test power done");
      stop_test;
   end
endmodule // lpddr2_command_decoder_bench
